/* timer16_interval_capture_pwm_bench.sv */
`timescale 1ns/1ps
// ************************************************************
// testbench
// ************************************************************
module timer16_interval_capture_pwm_bench;
  reg        clk_sys, rst, reg_wr_en, irq_mask_bit3, ovf_service_ack, mc_service_ack;
  reg  [7:0] reg_addr, reg_wr_data;
  reg  [1:0] port_two_cap_sel;
  wire [7:0] reg_rd_data_ff, irq_vector_ff;
  wire [1:0] irq_level_ff;
  wire       ext_count_clock_in, capture_in, match_toggle_out_ff;
  wire       overflow_request_ff, match_capture_request_ff, irq_req_ff;
  integer    errors, checks_done, cycles, seed, tmp, k, n, sh, cnt;
  reg  [15:0] r, v;
  reg  [7:0] exp_q [$];
  event      rd_seen;

  tmr16_timer #(.CNT_W(16)) i_tmr16_timer (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data_ff(reg_rd_data_ff), .ext_count_clock_in(ext_count_clock_in),
    .capture_in(capture_in), .match_toggle_out_ff(match_toggle_out_ff),
    .port_two_cap_sel(port_two_cap_sel), .irq_mask_bit3(irq_mask_bit3),
    .ovf_service_ack(ovf_service_ack), .mc_service_ack(mc_service_ack),
    .overflow_request_ff(overflow_request_ff), .match_capture_request_ff(match_capture_request_ff),
    .irq_req_ff(irq_req_ff), .irq_level_ff(irq_level_ff), .irq_vector_ff(irq_vector_ff));
  tmr16_pin_model i_tmr16_pin_model (.clk_sys(clk_sys),
    .ext_count_clock_in(ext_count_clock_in), .capture_in(capture_in));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [8*12:1] name, input [15:0] e, input [15:0] s);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("[FAIL] %0s expected %h seen %h", name, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr    = a;
      reg_wr_data = d;
      reg_wr_en   = 1'b1;
      @(negedge clk_sys);
      reg_wr_en   = 1'b0;
    end
  endtask
  // read data lags the address by one edge; two edges let a write settle
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      exp_q.push_back(e);
      repeat (2) @(negedge clk_sys);
      -> rd_seen;
    end
  endtask
  task rd_cnt(output [15:0] c);
    begin
      @(negedge clk_sys);
      reg_addr = 8'h02;
      repeat (2) @(negedge clk_sys);
      c[15:8]  = reg_rd_data_ff;
      reg_addr = 8'h03;
      repeat (2) @(negedge clk_sys);
      c[7:0]   = reg_rd_data_ff;
    end
  endtask
  task ack(input reg ovf);
    begin
      @(negedge clk_sys);
      if (ovf) ovf_service_ack = 1'b1;
      else mc_service_ack = 1'b1;
      @(negedge clk_sys);
      ovf_service_ack = 1'b0;
      mc_service_ack  = 1'b0;
    end
  endtask
  task wait_toggle(output integer c);
    reg p;
    begin
      p = match_toggle_out_ff;
      c = 0;
      while (match_toggle_out_ff === p && c < 100) begin
        @(negedge clk_sys);
        c = c + 1;
      end
    end
  endtask

  always @(rd_seen) chk("rd_data", {8'h00, exp_q[0]}, {8'h00, reg_rd_data_ff});
  always @(rd_seen) #1 exp_q.pop_front();
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 95000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end

  initial begin
    {errors, checks_done, cycles} = 0;
    seed = 6428;
    {rst, reg_addr, reg_wr_en, reg_wr_data, port_two_cap_sel} = {1'b1, 19'h0};
    {irq_mask_bit3, ovf_service_ack, mc_service_ack} = 3'h0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk("level", 16'h3, {14'h0, irq_level_ff});
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
    for (k = 0; k < 5; k = k + 1) begin
      sh = (k == 0) ? 10 : (k == 1) ? 8 : (k == 2) ? 6 : (k == 3) ? 3 : 0;
      wr(8'h01, {k[2:0], 5'h04});
      repeat (2048) @(negedge clk_sys);
      wr(8'h01, 8'he0);
      rd_cnt(v);
      cnt = v;
      chk("div count", 16'h1, {15'h0, cnt + 2 >= (2048 >> sh) && cnt <= (2048 >> sh) + 2});
    end
    wr(8'h01, 8'he4);
    wr(8'h03, 8'h55);
    repeat (100) @(negedge clk_sys);
    rd(8'h03, 8'h00);
    for (k = 0; k < 2; k = k + 1) begin
      wr(8'h01, k ? 8'ha4 : 8'hc4);
      i_tmr16_pin_model.ext_pulses(20);
      wr(8'h01, 8'he0);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h14);
    end
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h04);
    wr(8'h01, 8'h86);
    wait_toggle(n);
    wait_toggle(n);
    chk("toggle gap", 16'd5, n[15:0]);
    chk("mc request", 16'h1, {15'h0, irq_req_ff});
    chk("mc vector", 16'hd8, {8'h0, irq_vector_ff});
    wr(8'h01, 8'he0);
    chk("req masked", 16'h0, {15'h0, irq_req_ff});
    rd(8'h06, 8'h08);
    ack(1'b0);
    rd(8'h06, 8'h08);
    irq_mask_bit3 = 1'b1;
    ack(1'b0);
    rd(8'h06, 8'h00);
    wr(8'h01, 8'hfc);
    tmp = $random(seed);
    r = tmp[15:0] | 16'h0001;
    wr(8'h04, r[15:8]);
    wr(8'h05, r[7:0]);
    repeat (3) @(negedge clk_sys);
    chk("pwm high", 16'h1, {15'h0, match_toggle_out_ff});
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk("pwm low", 16'h0, {15'h0, match_toggle_out_ff});
    for (k = 0; k < 2; k = k + 1) begin
      wr(8'h04, r[15:8]);
      wr(8'h05, r[7:0]);
      wr(8'h06, 8'h00);
      wr(8'h01, k ? 8'hf4 : 8'hec);
      port_two_cap_sel = k ? 2'h0 : 2'h1;
      i_tmr16_pin_model.cap_to(1'b1);
      rd(8'h05, r[7:0]);
      i_tmr16_pin_model.cap_to(1'b0);
      rd(8'h04, k ? 8'h00 : r[15:8]);
      rd(8'h06, k ? 8'h08 : 8'h00);
      port_two_cap_sel = 2'h0;
      i_tmr16_pin_model.cap_to(k ? 1'b0 : 1'b1);
      rd(8'h05, 8'h00);
    end
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h00);
    wr(8'h01, 8'h9d);
    repeat (100) @(negedge clk_sys);
    chk("pwm run", 16'h1, {15'h0, match_toggle_out_ff});
    n = 100;
    while (overflow_request_ff !== 1'b1 && n < 70000) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk("wrap time", 16'h1, {15'h0, n > 65530 && n < 65542});
    chk("ovf vector", 16'hda, {8'h0, irq_vector_ff});
    wr(8'h01, 8'hf9);
    ack(1'b1);
    rd(8'h06, 8'h08);
    report_and_stop;
  end
endmodule // timer16_interval_capture_pwm_bench

/* tmr16_edge_sync.v */
`timescale 1ns/1ps

module tmr16_edge_sync (
  // clock and reset
  input  wire clk_sys,
  input  wire rst,
  // pin
  input  wire pin_in,
  // one-cycle edge pulses
  output wire rise,
  output wire fall
);

  // ************************************************************
  // two-stage synchroniser plus history
  // ************************************************************
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  always @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // only the second stage and its history feed the detector
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule // tmr16_edge_sync

/* tmr16_pin_model.sv */
`timescale 1ns/1ps
// ************************************************************
// far side pins: external count clock and capture source
// ************************************************************
module tmr16_pin_model (
  // clock
  input  wire clk_sys,
  // pins
  output reg  ext_count_clock_in,
  output reg  capture_in
);
  initial begin
    ext_count_clock_in = 1'b0;
    capture_in         = 1'b0;
  end
  // clock stands low between bursts; 3 cycle phases outrun the 2 ff sync
  task ext_pulses(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        repeat (3) @(negedge clk_sys);
        ext_count_clock_in = 1'b1;
        repeat (3) @(negedge clk_sys);
        ext_count_clock_in = 1'b0;
      end
      repeat (6) @(negedge clk_sys);
    end
  endtask
  task cap_to(input reg lvl);
    begin
      @(negedge clk_sys);
      capture_in = lvl;
      repeat (6) @(negedge clk_sys);
    end
  endtask
endmodule // tmr16_pin_model

/* tmr16_prescaler.v */
`timescale 1ns/1ps
`include "tmr16_regs.vh"

module tmr16_prescaler #(
  parameter WIDTH = `TMR16_PRESCALE_W
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // selection
  input  wire [2:0] clk_sel,
  // one-cycle count enable
  output reg        tick
);

  // ************************************************************
  // free running divider
  // ************************************************************
  reg [WIDTH-1:0] div_ff;

  always @(posedge clk_sys) begin
    if (rst) begin
      div_ff <= {WIDTH{1'b0}};
    end else begin
      div_ff <= div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // a divide-by-n tick fires when the low bits are all ones
  always @* begin
    case (clk_sel)
      `TMR16_CLK_DIV1024: tick = &div_ff[9:0];
      `TMR16_CLK_DIV256:  tick = &div_ff[7:0];
      `TMR16_CLK_DIV64:   tick = &div_ff[5:0];
      `TMR16_CLK_DIV8:    tick = &div_ff[2:0];
      `TMR16_CLK_DIV1:    tick = 1'b1;
      default:            tick = 1'b0;
    endcase
  end

endmodule // tmr16_prescaler

/* tmr16_regs.vh */
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH

// ************************************************************
// register offsets
// ************************************************************
`define TMR16_OFS_CONTROL    8'h01
`define TMR16_OFS_COUNT_HI   8'h02
`define TMR16_OFS_COUNT_LO   8'h03
`define TMR16_OFS_REF_HI     8'h04
`define TMR16_OFS_REF_LO     8'h05
`define TMR16_OFS_PENDING    8'h06

// ************************************************************
// control fields and reset value
// ************************************************************
`define TMR16_CONTROL_RST    8'h00
`define TMR16_CLKSEL_HI      7
`define TMR16_CLKSEL_LO      5
`define TMR16_MODE_HI        4
`define TMR16_MODE_LO        3
`define TMR16_CLR_BIT        2
`define TMR16_MCIE_BIT       1
`define TMR16_OVIE_BIT       0

// ************************************************************
// clock select codes
// ************************************************************
`define TMR16_CLK_DIV1024    3'h0
`define TMR16_CLK_DIV256     3'h1
`define TMR16_CLK_DIV64      3'h2
`define TMR16_CLK_DIV8       3'h3
`define TMR16_CLK_DIV1       3'h4
`define TMR16_CLK_EXT_FALL   3'h5
`define TMR16_CLK_EXT_RISE   3'h6
`define TMR16_CLK_STOP       3'h7

// ************************************************************
// modes
// ************************************************************
`define TMR16_MODE_INTERVAL  2'h0
`define TMR16_MODE_CAP_RISE  2'h1
`define TMR16_MODE_CAP_FALL  2'h2
`define TMR16_MODE_PWM       2'h3

// ************************************************************
// pending flags, vectors, level, capture source
// ************************************************************
`define TMR16_PEND_OVF_BIT   2
`define TMR16_PEND_MC_BIT    3
`define TMR16_VECTOR_OVF     8'hda
`define TMR16_VECTOR_MC      8'hd8
`define TMR16_IRQ_LEVEL      2'h3
`define TMR16_CAPSRC_PIN     2'h0
`define TMR16_PRESCALE_W     10

`endif

/* tmr16_timer.v */
`timescale 1ns/1ps
`include "tmr16_regs.vh"

module tmr16_timer #(
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr_en,
  input  wire [7:0] reg_wr_data,
  output reg  [7:0] reg_rd_data_ff,
  // pins
  input  wire       ext_count_clock_in,
  input  wire       capture_in,
  output reg        match_toggle_out_ff,
  // port and interrupt controller side
  input  wire [1:0] port_two_cap_sel,
  input  wire       irq_mask_bit3,
  input  wire       ovf_service_ack,
  input  wire       mc_service_ack,
  // requests towards the interrupt controller
  output reg        overflow_request_ff,
  output reg        match_capture_request_ff,
  output reg        irq_req_ff,
  output reg  [1:0] irq_level_ff,
  output reg  [7:0] irq_vector_ff
);

  // ************************************************************
  // state
  // ************************************************************
  reg  [7:0]       ctrl_ff;
  reg  [CNT_W-1:0] count_ff;
  reg  [CNT_W-1:0] ref_ff;
  reg  [7:0]       nxt_ctrl;
  reg  [CNT_W-1:0] nxt_count;
  reg  [CNT_W-1:0] nxt_ref;
  reg              nxt_out;
  reg              nxt_ovf;
  reg              nxt_mc;
  reg  [7:0]       nxt_rd;
  reg              ev_ovf;
  reg              ev_mc;
  reg              tick;
  wire             div_tick;
  wire             ext_rise;
  wire             ext_fall;
  wire             cap_rise;
  wire             cap_fall;
  wire [2:0]       clk_sel;
  wire [1:0]       mode;
  wire             at_match;
  wire             cap_edge;
  wire             pwm_level;
  reg              ovf_live;
  reg              mc_live;
  reg              nxt_req;
  reg  [7:0]       nxt_vector;
  wire             wr_ctrl;
  wire             wr_ref_hi;
  wire             wr_ref_lo;
  wire             wr_pend;
  wire             is_interval;
  wire             is_pwm;
  wire             is_cap_rise;
  wire             is_cap_fall;

  assign clk_sel = ctrl_ff[`TMR16_CLKSEL_HI:`TMR16_CLKSEL_LO];
  assign mode    = ctrl_ff[`TMR16_MODE_HI:`TMR16_MODE_LO];

  // ************************************************************
  // register write and mode decode
  // ************************************************************
  assign wr_ctrl     = reg_wr_en & (reg_addr == `TMR16_OFS_CONTROL);
  assign wr_ref_hi   = reg_wr_en & (reg_addr == `TMR16_OFS_REF_HI);
  assign wr_ref_lo   = reg_wr_en & (reg_addr == `TMR16_OFS_REF_LO);
  assign wr_pend     = reg_wr_en & (reg_addr == `TMR16_OFS_PENDING);
  assign is_interval = (mode == `TMR16_MODE_INTERVAL);
  assign is_pwm      = (mode == `TMR16_MODE_PWM);
  assign is_cap_rise = (mode == `TMR16_MODE_CAP_RISE);
  assign is_cap_fall = (mode == `TMR16_MODE_CAP_FALL);

  // ************************************************************
  // count sources
  // ************************************************************
  tmr16_prescaler #(
    .WIDTH (`TMR16_PRESCALE_W)
  ) u_prescaler (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_sel (clk_sel),
    .tick    (div_tick)
  );

  tmr16_edge_sync u_ext_clk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (ext_count_clock_in),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  tmr16_edge_sync u_capture (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (capture_in),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  // the external clock is sampled once per cycle, so it must stay below half of clk_sys
  always @* begin
    case (clk_sel)
      `TMR16_CLK_EXT_FALL: tick = ext_fall;
      `TMR16_CLK_EXT_RISE: tick = ext_rise;
      `TMR16_CLK_STOP:     tick = 1'b0;
      default:             tick = div_tick;
    endcase
  end

  // ************************************************************
  // compare and capture
  // ************************************************************
  assign at_match  = (count_ff == ref_ff);
  assign pwm_level = (ref_ff > count_ff);

  // capture gated by the port source select
  assign cap_edge = (port_two_cap_sel == `TMR16_CAPSRC_PIN) &
                    ((is_cap_rise & cap_rise) |
                     (is_cap_fall & cap_fall));

  // ************************************************************
  // counter and events
  // ************************************************************
  always @* begin
    nxt_count = count_ff;
    ev_ovf    = 1'b0;
    ev_mc     = 1'b0;
    if (tick) begin
      if (is_interval && at_match) begin
        nxt_count = {CNT_W{1'b0}};
        ev_mc     = 1'b1;
      end else begin
        nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        ev_ovf    = &count_ff;
      end
    end
    // the clear strobe overrides a tick in the same cycle
    if (ctrl_ff[`TMR16_CLR_BIT]) begin
      nxt_count = {CNT_W{1'b0}};
    end
    if (cap_edge) begin
      ev_mc = 1'b1;
    end
  end

  // ************************************************************
  // output pin: toggle in interval mode, level in pwm mode
  // ************************************************************
  always @* begin
    nxt_out = match_toggle_out_ff;
    if (tick && is_interval && at_match) begin
      nxt_out = ~match_toggle_out_ff;
    end
    if (is_pwm) begin
      nxt_out = pwm_level;
    end
  end

  // ************************************************************
  // reference register
  // ************************************************************
  always @* begin
    nxt_ref = ref_ff;
    if (wr_ref_hi) begin
      nxt_ref[15:8] = reg_wr_data;
    end
    if (wr_ref_lo) begin
      nxt_ref[7:0] = reg_wr_data;
    end
    // a capture beats a simultaneous software write to the reference register
    if (cap_edge) begin
      nxt_ref = count_ff;
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always @* begin
    nxt_ctrl = ctrl_ff;
    // the clear bit drops once the counter has been cleared
    nxt_ctrl[`TMR16_CLR_BIT] = 1'b0;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wr_data;
    end
  end

  // ************************************************************
  // overflow pending flag, set wins over clear
  // ************************************************************
  always @* begin
    nxt_ovf = overflow_request_ff;
    if (ovf_service_ack) begin
      nxt_ovf = 1'b0;
    end
    if (wr_pend && !reg_wr_data[`TMR16_PEND_OVF_BIT]) begin
      nxt_ovf = 1'b0;
    end
    if (ev_ovf) begin
      nxt_ovf = 1'b1;
    end
  end

  // ************************************************************
  // match/capture pending flag, set wins over clear
  // ************************************************************
  always @* begin
    nxt_mc = match_capture_request_ff;
    // hardware clears on service only while mask bit three is set
    if (mc_service_ack && irq_mask_bit3) begin
      nxt_mc = 1'b0;
    end
    if (wr_pend && !reg_wr_data[`TMR16_PEND_MC_BIT]) begin
      nxt_mc = 1'b0;
    end
    if (ev_mc) begin
      nxt_mc = 1'b1;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always @* begin
    case (reg_addr)
      `TMR16_OFS_CONTROL:  nxt_rd = ctrl_ff;
      `TMR16_OFS_COUNT_HI: nxt_rd = count_ff[15:8];
      `TMR16_OFS_COUNT_LO: nxt_rd = count_ff[7:0];
      `TMR16_OFS_REF_HI:   nxt_rd = ref_ff[15:8];
      `TMR16_OFS_REF_LO:   nxt_rd = ref_ff[7:0];
      `TMR16_OFS_PENDING:  nxt_rd = {4'h0, match_capture_request_ff,
                                     overflow_request_ff, 2'h0};
      default:             nxt_rd = 8'h00;
    endcase
  end

  // ************************************************************
  // interrupt request next values
  // ************************************************************
  // requests reach the controller only when enabled; overflow vector first
  always @* begin
    ovf_live   = nxt_ovf & nxt_ctrl[`TMR16_OVIE_BIT];
    mc_live    = nxt_mc & nxt_ctrl[`TMR16_MCIE_BIT];
    nxt_req    = ovf_live | mc_live;
    nxt_vector = `TMR16_VECTOR_MC;
    if (ovf_live) begin
      nxt_vector = `TMR16_VECTOR_OVF;
    end
  end

  // ************************************************************
  // control, counter and reference flip-flops
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff  <= `TMR16_CONTROL_RST;
      count_ff <= {CNT_W{1'b0}};
      ref_ff   <= {CNT_W{1'b0}};
    end else begin
      ctrl_ff  <= nxt_ctrl;
      count_ff <= nxt_count;
      ref_ff   <= nxt_ref;
    end
  end

  // ************************************************************
  // pin and pending flag flip-flops
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      match_toggle_out_ff      <= 1'b0;
      overflow_request_ff      <= 1'b0;
      match_capture_request_ff <= 1'b0;
    end else begin
      match_toggle_out_ff      <= nxt_out;
      overflow_request_ff      <= nxt_ovf;
      match_capture_request_ff <= nxt_mc;
    end
  end

  // ************************************************************
  // interrupt controller outputs
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      irq_req_ff    <= 1'b0;
      irq_level_ff  <= `TMR16_IRQ_LEVEL;
      irq_vector_ff <= `TMR16_VECTOR_OVF;
    end else begin
      irq_req_ff    <= nxt_req;
      irq_level_ff  <= `TMR16_IRQ_LEVEL;
      irq_vector_ff <= nxt_vector;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rd_data_ff <= 8'h00;
    end else begin
      reg_rd_data_ff <= nxt_rd;
    end
  end

endmodule // tmr16_timer

/* tmr16_timer_asserts.sv */
`timescale 1ns/1ps
// ************************************************************
// port checker
// ************************************************************
module tmr16_timer_checker #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire       clk_sys,
  input wire       rst,
  // register port
  input wire [7:0] reg_addr,
  input wire       reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data_ff,
  // pin and service side
  input wire       match_toggle_out_ff,
  input wire       irq_mask_bit3,
  input wire       ovf_service_ack,
  input wire       mc_service_ack,
  // requests
  input wire       overflow_request_ff,
  input wire       match_capture_request_ff,
  input wire       irq_req_ff,
  input wire [1:0] irq_level_ff,
  input wire [7:0] irq_vector_ff
);
  reg  [7:0] last_ctrl_ff;
  wire       pend_wr = reg_wr_en && reg_addr == 8'h06;
  always @(posedge clk_sys) begin
    if (reg_wr_en && reg_addr == 8'h01) begin
      last_ctrl_ff <= reg_wr_data;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ctrl_wr_s;
    (reg_wr_en && reg_addr == 8'h01) ##1 (!reg_wr_en && reg_addr == 8'h01) [*2];
  endsequence
  level_fixed_a: assert property (irq_level_ff == 2'h3)
    else $error("level not three");
  vector_ovf_a: assert property (irq_req_ff && !match_capture_request_ff |->
    irq_vector_ff == 8'hda) else $error("overflow vector wrong");
  vector_mc_a: assert property (irq_req_ff && !overflow_request_ff |->
    irq_vector_ff == 8'hd8) else $error("match vector wrong");
  req_cause_a: assert property (irq_req_ff |->
    overflow_request_ff || match_capture_request_ff) else $error("request without flag");
  mc_flag_hold_a: assert property (match_capture_request_ff &&
    !(mc_service_ack && irq_mask_bit3) && !(pend_wr && !reg_wr_data[3])
    |=> match_capture_request_ff) else $error("match flag lost");
  ovf_flag_hold_a: assert property (overflow_request_ff && !ovf_service_ack &&
    !(pend_wr && !reg_wr_data[2]) |=> overflow_request_ff) else $error("overflow flag lost");
  pend_read_a: assert property (reg_addr == 8'h06 |=> reg_rd_data_ff == {4'h0,
    $past(match_capture_request_ff), $past(overflow_request_ff), 2'h0})
    else $error("pending read wrong");
  clr_self_a: assert property (ctrl_wr_s |=> reg_rd_data_ff ==
    {last_ctrl_ff[7:3], 1'b0, last_ctrl_ff[1:0]}) else $error("clear bit stuck");
  reset_out_a: assert property ($fell(rst) |-> !overflow_request_ff &&
    !match_capture_request_ff && !irq_req_ff && irq_vector_ff == 8'hda)
    else $error("reset outputs wrong");
  cover property (irq_req_ff && irq_vector_ff == 8'hda);
  cover property ($rose(match_capture_request_ff));
  cover property (mc_service_ack && irq_mask_bit3 && match_capture_request_ff);
endmodule // tmr16_timer_checker

bind tmr16_timer tmr16_timer_checker #(.CNT_W(CNT_W)) i_tmr16_timer_checker (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_data_ff(reg_rd_data_ff),
  .match_toggle_out_ff(match_toggle_out_ff), .irq_mask_bit3(irq_mask_bit3),
  .ovf_service_ack(ovf_service_ack), .mc_service_ack(mc_service_ack),
  .overflow_request_ff(overflow_request_ff), .match_capture_request_ff(match_capture_request_ff),
  .irq_req_ff(irq_req_ff), .irq_level_ff(irq_level_ff), .irq_vector_ff(irq_vector_ff)
);
